// *** bench/lglp_link_asserts.sv ***
`default_nettype none
module lglp_link_asserts (
	input wire logic        data_shift_clock,
	input wire logic        link_rst_n,
	input wire logic        latch_select,
	input wire logic        transfer_enable_n,
	input wire logic        latch_ctl,
	input wire logic        mode_16,
	input wire logic        brightness_ctrl_enable,
	input wire logic        blank,
	input wire logic        gray_count_clock,
	input wire logic [15:0] driver_output,
	input wire logic [4:0]  current_step,
	input wire logic [2:0]  gray_div_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       gck_q;    // gray clock at last link edge
	logic [3:0] gsince_q; // link edges since a gray fall, saturating
	logic       lk;       // causes allowed to move the brightness latch
	logic       pair_eq;  // every tied pair agrees
	assign lk = latch_ctl || !brightness_ctrl_enable;
	assign pair_eq = (driver_output & 16'h5555) == ((driver_output >> 1) & 16'h5555);
	default clocking @(posedge data_shift_clock); endclocking
	default disable iff (!link_rst_n);
	// gray falls seen with the device's own sampling clock
	always_ff @(posedge data_shift_clock) begin
		if (!link_rst_n) begin
			gck_q <= 1'b0;
			gsince_q <= 4'h0;
		end else begin
			gck_q <= gray_count_clock;
			if (gck_q && !gray_count_clock)
				gsince_q <= 4'h0;
			else if (gsince_q != 4'hf)
				gsince_q <= gsince_q + 4'h1;
		end
	end
	a_blank_forces_off: assert property (blank |=> driver_output == 16'h0000)
		else $error("outputs lit under blank");
	a_output_on_gray: assert property ($changed(driver_output) && !$past(blank) |-> gsince_q <= 4'h2)
		else $error("outputs moved away from a gray fall");
	a_step_needs_latch: assert property ($changed(current_step) |-> $past(lk) || $past(lk, 2) || $past(lk, 3))
		else $error("brightness moved while latch held");
	a_gray_leaves_bc: assert property (latch_ctl && !latch_select && brightness_ctrl_enable |=> $stable(current_step) [*2])
		else $error("gray latch disturbed brightness");
	a_bc_default: assert property (!brightness_ctrl_enable [*3] |=> current_step == 5'h1f && gray_div_code == 3'h0)
		else $error("brightness default not forced");
	a_pair_tied: assert property (!mode_16 [*8] |-> pair_eq)
		else $error("tied pair differs");
	a_xfer_one_period: assert property ($fell(transfer_enable_n) |=> transfer_enable_n)
		else $error("shift enable longer than one period");
	a_latch_one_period: assert property ($rose(latch_ctl) |=> !latch_ctl)
		else $error("latch pulse longer than one period");
	a_bc_only_blank: assert property (latch_ctl && latch_select |-> blank)
		else $error("brightness latched while lit");
	c_lit16: cover property (mode_16 && !blank && driver_output[15]);
	c_lit8: cover property (!mode_16 && !blank && driver_output[0]);
	c_bc_latch: cover property (latch_ctl && latch_select);
endmodule // lglp_link_asserts
`default_nettype wire

// *** bench/lglp_tb.sv ***
`include "lglp_regs.svh"
`default_nettype none
module lglp_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk    = 1'b0; // 100 MHz
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr  = 4'h0;
	logic [3:0]  araddr  = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        arvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] drv;
	logic [4:0]  step;
	logic [2:0]  div;
	logic [7:0]  v [16];     // expected on counts per output
	int          bad_count = 0;
	int          checked = 0;
	lglp_link_if link ();
	always #5 aclk = ~aclk;
	// responses are always accepted at once, so ready stays high
	lglp_host lglp_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .link(link));
	lglp_dev lglp_dev_i (.link(link), .driver_output(drv), .current_step(step), .gray_div_code(div));
	lglp_link_asserts lglp_link_asserts_i (.data_shift_clock(link.data_shift_clock), .link_rst_n(link.link_rst_n),
		.latch_select(link.latch_select), .transfer_enable_n(link.transfer_enable_n), .latch_ctl(link.latch_ctl),
		.mode_16(link.mode_16), .brightness_ctrl_enable(link.brightness_ctrl_enable), .blank(link.blank),
		.gray_count_clock(link.gray_count_clock), .driver_output(drv), .current_step(step), .gray_div_code(div));
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// on time may slip by one and a half link periods at either end
	task automatic cmp_int(input int got, input int exp);
		checked++;
		if (got < exp - 24 || got > exp + 24) begin
			bad_count++;
			$display("unexpected at %0t: on %0d want %0d", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axw(a, d, r);
		cmp_word({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		cmp_word(d, ed);
		cmp_word({30'h0, r}, {30'h0, er});
	endtask
	// commands are dropped while busy, so every one waits for idle
	task automatic cmd(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] s;
		logic [1:0]  r;
		wr(a, d, `LGLP_RESP_OKAY);
		s = 32'h1;
		while (s[`LGLP_ST_BUSY] === 1'b1)
			axr(`LGLP_OFF_STATUS, s, r);
		repeat (64) @(posedge aclk);
	endtask
	// start counting and sum each output's lit cycles
	task automatic run_pwm(input logic [3:0] ctl);
		int   on [16];
		logic unk;
		on = '{default: 0};
		unk = 1'b0;
		wr(`LGLP_OFF_CTRL, {28'h0, ctl}, `LGLP_RESP_OKAY);
		repeat (9000) begin
			@(posedge aclk);
			unk |= $isunknown(drv);
			for (int k = 0; k < 16; k++)
				on[k] += int'(drv[k] === 1'b1);
		end
		// the counts treat unknown as off, so unknowns are caught apart
		cmp_word({31'h0, unk}, 32'h0);
		for (int k = 0; k < 16; k++)
			cmp_int(on[k], int'(v[k]) * (`LGLP_GRAY_NS / `LGLP_ACLK_NS));
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// watchdog well beyond the roughly 22000 cycles of the tests
	initial begin
		repeat (80000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		// the host keeps the link reset until the device has seen a rising edge
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`LGLP_OFF_CTRL, 32'h4, `LGLP_RESP_OKAY);
		rd(`LGLP_OFF_STATUS, 32'h0, `LGLP_RESP_OKAY);
		rd(4'h2, 32'h0, `LGLP_RESP_SLVERR);
		wr(4'h6, 32'h0, `LGLP_RESP_SLVERR);
		repeat (64) @(posedge aclk);
		cmp_word({27'h0, step}, 32'h1f);
		$display("test bus and reset done");
		cmd(`LGLP_OFF_CTRL, 32'h6);
		cmd(`LGLP_OFF_SHIFT, 32'h1a5);
		cmd(`LGLP_OFF_LATCH, 32'h100);
		cmp_word({27'h0, step}, 32'h5);
		cmp_word({29'h0, div}, 32'h5);
		rd(`LGLP_OFF_STATUS, 32'h2, `LGLP_RESP_OKAY);
		cmd(`LGLP_OFF_CTRL, 32'h2);
		cmd(`LGLP_OFF_SHIFT, 32'h13c);
		cmd(`LGLP_OFF_LATCH, 32'h100);
		cmp_word({27'h0, step}, 32'h5);
		cmd(`LGLP_OFF_CTRL, 32'h4);
		cmp_word({27'h0, step}, 32'h1f);
		$display("test brightness done");
		cmd(`LGLP_OFF_CTRL, 32'h5);
		for (int k = 15; k >= 0; k--) begin
			v[k] = (k == 15) ? 8'h80 : 8'(k);
			cmd(`LGLP_OFF_SHIFT, {24'h0, v[k]});
		end
		cmd(`LGLP_OFF_LATCH, 32'h0);
		run_pwm(4'h9);
		$display("test sixteen outputs done");
		cmd(`LGLP_OFF_CTRL, 32'h4);
		for (int j = 7; j >= 0; j--) begin
			v[2 * j] = 8'(j + 1);
			v[2 * j + 1] = 8'(j + 1);
			cmd(`LGLP_OFF_SHIFT, {24'h0, v[2 * j]});
		end
		cmd(`LGLP_OFF_LATCH, 32'h0);
		wr(`LGLP_OFF_CTRL, 32'h8, `LGLP_RESP_OKAY);
		repeat (200) @(posedge aclk);
		cmp_word({30'h0, drv[15:14]}, 32'h3);
		cmd(`LGLP_OFF_CTRL, 32'hc);
		cmp_word({16'h0, drv}, 32'h0);
		run_pwm(4'h8);
		$display("test eight outputs done");
		report_and_stop();
	end
endmodule // lglp_tb
`default_nettype wire

// *** rtl/lglp_dev.sv ***
// Contract
// RULE_01: mode high drives 16 outputs, low 8
// RULE_02: gray latch holds eight or sixteen bytes
// RULE_03: select low gray scale, high brightness
// RULE_04: data bit 0 lsb, bit 7 msb
// RULE_05: output on while count below value
// RULE_06: brightness is one byte, shared pins
// RULE_07: enable low forces brightness to 1fh
// RULE_08: latch undefined after power-up, host writes
// RULE_09: host never rewrites brightness while lit
// RULE_10: mode changes shift length and latch mapping
// RULE_11: transfer enable low shifts one byte
// RULE_12: latch high passes through, low holds
// RULE_13: low five bits current, high three divider
// RULE_14: blank high forces every output off
// RULE_15: eight mode drives tied pairs identically
`include "lglp_regs.svh"
`default_nettype none
module lglp_dev
	import lglp_pkg::*;
(
	lglp_link_if.dev   link,           // pins from the display controller
	output logic [15:0] driver_output,  // driver on levels, bit 0 first
	output logic [4:0]  current_step,   // output current step code
	output logic [2:0]  gray_div_code   // gray clock division code
);

	lglp_dev_t r_q;        // registered state
	lglp_dev_t r_d;        // next state
	logic [15:0] on_next;  // per output compare result
	logic [7:0]  cnt_next; // counter value after this cycle
	logic        gck_fall; // a falling edge of the gray clock
	logic        tick;     // a counted, divided gray clock edge

	// falling edge from the second synchroniser stage only
	assign gck_fall = r_q.gck_prev & ~r_q.gck_sync[1];
	// divide by code plus one; code 0 counts every edge
	assign tick = gck_fall & (r_q.div == r_q.bc_lat[7:5]); // [RULE_13]
	// first counted edge after blank release starts at zero
	assign cnt_next = !r_q.run ? 8'h00 :
		(r_q.cnt == 8'hff) ? 8'hff : r_q.cnt + 8'h01;

	// one compare per driver output
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_out
			logic [7:0] value; // gray scale value for this output
			// eight mode: entries 0 to 7 each feed a tied pair
			assign value = link.mode_16 ? r_q.gs_lat[gi] : r_q.gs_lat[gi / 2]; // [RULE_01] [RULE_15] [RULE_10]
			// strict compare: off once the count reaches the value
			assign on_next[gi] = (cnt_next < value); // [RULE_05]
		end
	endgenerate

	// next state for the whole device
	always_comb begin
		r_d = r_q;
		// gray clock comes from another clock, two stages first
		r_d.gck_sync = {r_q.gck_sync[0], link.gray_count_clock};
		r_d.gck_prev = r_q.gck_sync[1];

		// shifting: one byte per link clock edge while enabled
		if (!link.transfer_enable_n) begin // [RULE_11]
			if (link.latch_select) begin
				// brightness stage is a single byte
				r_d.bc_sh = link.data_in; // [RULE_03] [RULE_06]
			end else begin
				// new byte enters entry 0 and walks toward the last output
				for (int i = 15; i > 0; i--) begin
					r_d.gs_sh[i] = r_q.gs_sh[i - 1];
				end
				r_d.gs_sh[0] = link.data_in; // [RULE_04] [RULE_02]
			end
		end

		// transparent latches follow the shift contents while high
		if (link.latch_ctl) begin // [RULE_12]
			if (link.latch_select) begin
				r_d.bc_lat = r_d.bc_sh; // [RULE_03]
			end else begin
				r_d.gs_lat = r_d.gs_sh;
			end
		end
		// forced default wins over any latch write
		if (!link.brightness_ctrl_enable) begin
			r_d.bc_lat = `LGLP_BC_DEFAULT; // [RULE_07]
		end

		// pulse width counting
		if (link.blank) begin
			// blank clears the counter, divider and outputs so the next frame starts clean
			r_d.run  = 1'b0; // [RULE_14]
			r_d.cnt  = 8'h00;
			r_d.div  = 3'h0;
			r_d.outs = 16'h0000; // [RULE_14]
		end else if (gck_fall) begin
			if (tick) begin
				// a counted edge updates the counter and all outputs
				r_d.div  = 3'h0;
				r_d.run  = 1'b1;
				r_d.cnt  = cnt_next;
				r_d.outs = on_next; // [RULE_05]
			end else begin
				// edge swallowed by the divider
				r_d.div = r_q.div + 3'h1; // [RULE_13]
			end
		end
	end

	// single register for all state
	always_ff @(posedge link.data_shift_clock) begin
		if (!link.link_rst_n) begin
			// latch contents have no meaning until the host loads them
			r_q <= '0; // [RULE_08]
		end else begin
			r_q <= r_d;
		end
	end

	// outputs straight from state
	assign driver_output = r_q.outs;
	// current step has no analog here; it is reported out
	assign current_step  = r_q.bc_lat[4:0]; // [RULE_13]
	assign gray_div_code = r_q.bc_lat[7:5];

endmodule // lglp_dev
`default_nettype wire

// *** rtl/lglp_host.sv ***
`include "lglp_regs.svh"
`default_nettype none
module lglp_host
	import lglp_pkg::*;
#(
	parameter int unsigned LINK_HALF = `LGLP_LINK_HALF, // aclk cycles per link half period
	parameter int unsigned GRAY_HALF = `LGLP_GRAY_HALF  // aclk cycles per gray half period
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [`LGLP_AW-1:0]   s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`LGLP_AW-1:0]   s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	lglp_link_if.host                  link
);

	// gray half period counted in whole link periods, so it must divide evenly
	localparam int unsigned GRAY_LINKS = GRAY_HALF / (2 * LINK_HALF);

	lglp_host_t h_q;    // registered state
	lglp_host_t h_d;    // next state
	logic link_fall;    // link clock about to fall: pins change here
	logic wr_go;        // address and data both held
	logic busy;         // a pin sequence is pending

	assign link_fall = h_q.lclk & (h_q.ph == 8'(LINK_HALF - 1));
	assign wr_go     = h_q.aw_ok & h_q.w_ok & ~h_q.bvalid;
	assign busy      = (h_q.st != LGLP_IDLE);

	// next state for the whole host
	always_comb begin
		h_d = h_q;
		// every link pin moves on a link fall, never racing a device edge
		if (link_fall) begin
			// reset lifts only after the device has seen one rising edge in it
			h_d.rst_n = 1'b1;
			h_d.lctrl = h_q.ctrl;
		end
		// link clock divider, free running
		if (h_q.ph == 8'(LINK_HALF - 1)) begin
			h_d.ph   = 8'h00;
			h_d.lclk = ~h_q.lclk;
		end else begin
			h_d.ph = h_q.ph + 8'h01;
		end
		// gray clock divider, parked low when stopped
		if (!h_q.lctrl[`LGLP_CTRL_GRUN]) begin
			h_d.gph  = 8'h00;
			h_d.gclk = 1'b0;
		end else if (link_fall) begin
			// gray edges sit on link falls so the device samples them cleanly
			if (h_q.gph == 8'(GRAY_LINKS - 1)) begin
				h_d.gph  = 8'h00;
				h_d.gclk = ~h_q.gclk;
			end else begin
				h_d.gph = h_q.gph + 8'h01;
			end
		end

		// pin sequencer: every change lands on a link falling edge
		if (link_fall) begin
			case (h_q.st)
				LGLP_SH_WAIT: begin
					// select settles while the clock and latch are low
					h_d.sel    = h_q.pend_sel; // [RULE_03]
					h_d.data   = h_q.pend_byte;
					h_d.xfer_n = 1'b0; // [RULE_11]
					h_d.st     = LGLP_SH_ON;
				end
				LGLP_SH_ON: begin
					// exactly one rising edge saw the enable low
					h_d.xfer_n = 1'b1; // [RULE_11]
					h_d.st     = LGLP_IDLE;
				end
				LGLP_LT_WAIT: begin
					// blank lifted since the command was taken: drop it
					if (h_q.pend_sel && !h_q.ctrl[`LGLP_CTRL_BLANK]) begin // [RULE_09]
						h_d.st = LGLP_IDLE;
					end else begin
						h_d.sel     = h_q.pend_sel; // [RULE_03]
						h_d.latch   = 1'b1;
						h_d.bc_done = h_q.bc_done | h_q.pend_sel; // [RULE_08]
						h_d.st      = LGLP_LT_ON;
					end
				end
				LGLP_LT_ON: begin
					h_d.latch = 1'b0;
					h_d.st    = LGLP_IDLE;
				end
				default: begin
					h_d.st = LGLP_IDLE;
				end
			endcase
		end

		// write address and data channels, taken in either order
		if (s_axi_awvalid && h_q.awready) begin
			h_d.aw_ok  = 1'b1;
			h_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && h_q.wready) begin
			h_d.w_ok   = 1'b1;
			h_d.wdata  = s_axi_wdata;
			h_d.wstrb0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			h_d.bvalid = 1'b0;
		end
		// perform a write once both halves are in
		if (wr_go) begin
			h_d.aw_ok  = 1'b0;
			h_d.w_ok   = 1'b0;
			h_d.bvalid = 1'b1;
			h_d.bresp  = `LGLP_RESP_OKAY;
			case (h_q.awaddr)
				`LGLP_OFF_CTRL: begin
					if (h_q.wstrb0) begin
						h_d.ctrl = h_q.wdata[3:0];
					end
				end
				`LGLP_OFF_SHIFT: begin
					// a command while busy is dropped; poll status first
					if (h_q.wstrb0 && !busy) begin
						h_d.pend_byte = h_q.wdata[7:0];
						h_d.pend_sel  = h_q.wdata[`LGLP_CMD_SEL];
						h_d.st        = LGLP_SH_WAIT;
					end
				end
				`LGLP_OFF_LATCH: begin
					// brightness latch only rewritten while blanked
					if (h_q.wstrb0 && !busy && (!h_q.wdata[`LGLP_CMD_SEL] ||
						h_q.ctrl[`LGLP_CTRL_BLANK])) begin // [RULE_09]
						h_d.pend_sel = h_q.wdata[`LGLP_CMD_SEL];
						h_d.st       = LGLP_LT_WAIT;
					end
				end
				`LGLP_OFF_STATUS: begin
					// read only, write ignored
				end
				default: begin
					h_d.bresp = `LGLP_RESP_SLVERR;
				end
			endcase
		end
		h_d.awready = ~h_d.aw_ok & ~h_d.bvalid;
		h_d.wready  = ~h_d.w_ok & ~h_d.bvalid;

		// read channel
		if (s_axi_rvalid && s_axi_rready) begin
			h_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && h_q.arready) begin
			h_d.rvalid = 1'b1;
			h_d.rresp  = `LGLP_RESP_OKAY;
			h_d.rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				`LGLP_OFF_CTRL: begin
					h_d.rdata[3:0] = h_q.ctrl;
				end
				`LGLP_OFF_STATUS: begin
					h_d.rdata[`LGLP_ST_BUSY]    = busy;
					h_d.rdata[`LGLP_ST_BC_DONE] = h_q.bc_done;
				end
				`LGLP_OFF_SHIFT, `LGLP_OFF_LATCH: begin
					// command words read as zero
				end
				default: begin
					h_d.rresp = `LGLP_RESP_SLVERR;
				end
			endcase
		end
		h_d.arready = ~h_d.rvalid;
	end

	// single register for all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_q         <= '0;
			h_q.st      <= LGLP_IDLE;
			h_q.xfer_n  <= 1'b1;
			// blank on, brightness enable low until software sets it
			h_q.ctrl    <= `LGLP_CTRL_RST; // [RULE_07]
			h_q.lctrl   <= `LGLP_CTRL_RST;
			h_q.awready <= 1'b1;
			h_q.wready  <= 1'b1;
			h_q.arready <= 1'b1;
		end else begin
			h_q <= h_d;
		end
	end

	// bus outputs from state
	assign s_axi_awready = h_q.awready;
	assign s_axi_wready  = h_q.wready;
	assign s_axi_bvalid  = h_q.bvalid;
	assign s_axi_bresp   = h_q.bresp;
	assign s_axi_arready = h_q.arready;
	assign s_axi_rvalid  = h_q.rvalid;
	assign s_axi_rdata   = h_q.rdata;
	assign s_axi_rresp   = h_q.rresp;
	// link pins from state
	assign link.data_shift_clock       = h_q.lclk;
	assign link.link_rst_n             = h_q.rst_n;
	assign link.latch_select           = h_q.sel;
	assign link.data_in                = h_q.data;
	assign link.transfer_enable_n      = h_q.xfer_n;
	assign link.latch_ctl              = h_q.latch;
	assign link.mode_16                = h_q.lctrl[`LGLP_CTRL_MODE16];
	assign link.brightness_ctrl_enable = h_q.lctrl[`LGLP_CTRL_BC_EN];
	assign link.blank                  = h_q.lctrl[`LGLP_CTRL_BLANK];
	assign link.gray_count_clock       = h_q.gclk;

endmodule // lglp_host
`default_nettype wire

// *** rtl/lglp_link_if.sv ***
`default_nettype none
interface lglp_link_if;
	logic       data_shift_clock;       // link clock, made by the host
	logic       link_rst_n;             // synchronous reset on the link clock
	logic       latch_select;           // low gray scale, high brightness
	logic [7:0] data_in;                // byte lane, bit 0 is lsb
	logic       transfer_enable_n;      // low lets a rising edge shift
	logic       latch_ctl;              // high makes the latch transparent
	logic       mode_16;                // high 16 outputs, low 8
	logic       brightness_ctrl_enable; // low forces brightness default
	logic       blank;                  // high forces outputs off
	logic       gray_count_clock;       // pwm count clock

	modport host (output data_shift_clock, link_rst_n, latch_select, data_in,
		transfer_enable_n, latch_ctl, mode_16, brightness_ctrl_enable, blank, gray_count_clock);
	modport dev (input data_shift_clock, link_rst_n, latch_select, data_in,
		transfer_enable_n, latch_ctl, mode_16, brightness_ctrl_enable, blank, gray_count_clock);
endinterface : lglp_link_if
`default_nettype wire

// *** rtl/lglp_pkg.sv ***
`default_nettype none
package lglp_pkg;
	// host sequencer states, gray on each step away from idle; LGLP_SH_ON and LGLP_LT_ON flip two bits back to idle
	typedef enum logic [2:0] {
		LGLP_IDLE    = 3'h0,
		LGLP_SH_WAIT = 3'h1,
		LGLP_SH_ON   = 3'h3,
		LGLP_LT_WAIT = 3'h4,
		LGLP_LT_ON   = 3'h6
	} lglp_host_st_t;

	// all state of the device end
	typedef struct packed {
		logic [15:0][7:0] gs_sh;    // gray scale shift chain
		logic [15:0][7:0] gs_lat;   // gray scale latch
		logic [7:0]       bc_sh;    // brightness shift stage
		logic [7:0]       bc_lat;   // brightness latch
		logic [1:0]       gck_sync; // gray clock synchroniser
		logic             gck_prev; // for falling edge detect
		logic [2:0]       div;      // gray clock divider count
		logic [7:0]       cnt;      // gray scale counter
		logic             run;      // counting since blank release
		logic [15:0]      outs;     // driver outputs
	} lglp_dev_t;

	// all state of the host end
	typedef struct packed {
		lglp_host_st_t st;
		logic [7:0]  ph;       // link clock divider
		logic        lclk;
		logic [7:0]  gph;      // gray clock divider
		logic        gclk;
		logic        rst_n;
		logic        sel;
		logic [7:0]  data;
		logic        xfer_n;
		logic        latch;
		logic [3:0]  ctrl;
		logic [3:0]  lctrl;    // control copy shown on the pins, moves on link falls
		logic [7:0]  pend_byte;
		logic        pend_sel;
		logic        bc_done;
		logic        aw_ok;
		logic [3:0]  awaddr;
		logic        w_ok;
		logic [31:0] wdata;
		logic        wstrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lglp_host_t;
endpackage : lglp_pkg
`default_nettype wire

// *** rtl/lglp_regs.svh ***
`ifndef LGLP_REGS_SVH
`define LGLP_REGS_SVH
// register word offsets of the host controller
`define LGLP_AW          4
`define LGLP_OFF_CTRL    4'h0
`define LGLP_OFF_SHIFT   4'h4
`define LGLP_OFF_LATCH   4'h8
`define LGLP_OFF_STATUS  4'hc
// control register fields
`define LGLP_CTRL_MODE16 0
`define LGLP_CTRL_BC_EN  1
`define LGLP_CTRL_BLANK  2
`define LGLP_CTRL_GRUN   3
// shift and latch command fields
`define LGLP_CMD_SEL     8
// status register fields
`define LGLP_ST_BUSY     0
`define LGLP_ST_BC_DONE  1
// reset values and bus answers
`define LGLP_CTRL_RST    4'h4
`define LGLP_BC_DEFAULT  8'h1f
`define LGLP_RESP_OKAY   2'b00
`define LGLP_RESP_SLVERR 2'b10
// timing: aclk period 10 ns; link clock 160 ns, gray clock 640 ns
`define LGLP_ACLK_NS     10
`define LGLP_LINK_NS     160
`define LGLP_GRAY_NS     640
`define LGLP_LINK_HALF   (`LGLP_LINK_NS / (2 * `LGLP_ACLK_NS))
`define LGLP_GRAY_HALF   (`LGLP_GRAY_NS / (2 * `LGLP_ACLK_NS))
`endif
